// [flash_poll_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - start polling with two reads, compare toggle
// - toggling with fail bit high: recheck toggle
// - still toggling after fail: failure, reset command
// - resumed polling restarts the two-read procedure
// - window check skippable if commands under 50 us
// - sample window bit before and after commands
// - status reads use a valid address
module flash_poll_ctrl #(
   parameter int         ADDR_W    = 21,
   parameter logic [7:0] RESET_CMD = 8'hf0
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output var  logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output var  logic              s_axi_wready,
   output var  logic [1:0]        s_axi_bresp,
   output var  logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output var  logic              s_axi_arready,
   output var  logic [31:0]       s_axi_rdata,
   output var  logic [1:0]        s_axi_rresp,
   output var  logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output var  logic [ADDR_W-1:0] flash_addr,
   output var  logic              flash_ce_n,
   output var  logic              flash_oe_n,
   output var  logic              flash_we_n,
   output var  logic [7:0]        low_data_byte_out,
   output var  logic              low_data_byte_oe,
   input  wire logic [7:0]        low_data_byte_in,
   input  wire logic              ready_busy_pin,
   output var  logic              irq
);
   typedef struct packed {
      flash_poll_pkg::state_t state;
      flash_poll_pkg::state_t after;
      flash_poll_pkg::op_t    op;
      flash_poll_pkg::res_t   result;
      flash_poll_pkg::flash_ctl_t fl;
      logic [ADDR_W-1:0]      fl_addr;
      logic [7:0]             cnt;
      logic [1:0]             nread;
      logic [7:0]             cur;
      logic [7:0]             prev;
      logic                   fail_hi;
      logic                   abort;
      logic                   sec_tog;
      logic                   win;
      logic [ADDR_W-1:0]      addr_reg;
      logic [7:0]             wdata_reg;
      logic                   auto_rst;
      logic [flash_poll_pkg::IRQ_W-1:0] istat;
      logic [flash_poll_pkg::IRQ_W-1:0] imask;
      logic [2:0][7:0]        dq_sync;
      logic [2:0]             rb_sync;
      logic                   rb;
      logic                   awready, wready, bvalid, arready, rvalid;
      logic                   aw_got, w_got;
      logic [7:0]             awaddr;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic [1:0]             bresp, rresp;
      logic [31:0]            rdata;
      logic                   irq;
   } st_t;

   st_t s_ff, nxt_s;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic [7:0] cyc(input int n);
      return 8'(n);
   endfunction : cyc

   logic ev_ok, ev_fail, ev_win, ev_cmd, go, toggled;
   logic [flash_poll_pkg::IRQ_W-1:0] iset;
   logic [31:0] status_word, wmerged;

   always_comb begin
      nxt_s   = s_ff;
      ev_ok   = 1'b0;
      ev_fail = 1'b0;
      ev_win  = 1'b0;
      ev_cmd  = 1'b0;
      go      = 1'b0;
      wmerged = 32'h0;
      toggled = s_ff.cur[flash_poll_pkg::BIT_TOGGLE] ^ s_ff.prev[flash_poll_pkg::BIT_TOGGLE];
      status_word = {16'h0, s_ff.cur, 2'h0, s_ff.rb, s_ff.sec_tog, s_ff.win,
                     s_ff.result, s_ff.state != flash_poll_pkg::ST_IDLE};
      // ======================================================
      // pin synchronisers
      nxt_s.dq_sync = {s_ff.dq_sync[1:0], low_data_byte_in};
      nxt_s.rb_sync = {s_ff.rb_sync[1:0], ready_busy_pin};
      // busy pin counts only once the last two stages agree
      if (s_ff.rb_sync[1] == s_ff.rb_sync[2]) begin
         nxt_s.rb = s_ff.rb_sync[2];
      end
      // ======================================================
      // register bus, write side
      if (s_ff.awready && s_axi_awvalid) begin
         nxt_s.awaddr  = s_axi_awaddr;
         nxt_s.aw_got  = 1'b1;
         nxt_s.awready = 1'b0;
      end
      if (s_ff.wready && s_axi_wvalid) begin
         nxt_s.wdata  = s_axi_wdata;
         nxt_s.wstrb  = s_axi_wstrb;
         nxt_s.w_got  = 1'b1;
         nxt_s.wready = 1'b0;
      end
      if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp  = flash_poll_pkg::RESP_OKAY;
         case (s_ff.awaddr)
            flash_poll_pkg::OFF_CTRL: begin
               wmerged = merge(32'h0, s_ff.wdata, s_ff.wstrb);
               if (s_ff.wstrb[0]) begin
                  nxt_s.auto_rst = wmerged[flash_poll_pkg::CTRL_AUTORST];
                  // abort lets software leave the poll loop for other work
                  if (wmerged[flash_poll_pkg::CTRL_ABORT]) begin
                     nxt_s.abort = 1'b1;
                  end
                  go = wmerged[flash_poll_pkg::CTRL_GO];
               end
            end
            flash_poll_pkg::OFF_ADDR: begin
               wmerged = merge(32'(s_ff.addr_reg), s_ff.wdata, s_ff.wstrb);
               nxt_s.addr_reg = wmerged[ADDR_W-1:0];
            end
            flash_poll_pkg::OFF_WDATA: begin
               wmerged = merge(32'(s_ff.wdata_reg), s_ff.wdata, s_ff.wstrb);
               nxt_s.wdata_reg = wmerged[7:0];
            end
            flash_poll_pkg::OFF_ISTAT: begin
               if (s_ff.wstrb[0]) begin
                  nxt_s.istat = s_ff.istat & ~s_ff.wdata[flash_poll_pkg::IRQ_W-1:0];
               end
            end
            flash_poll_pkg::OFF_IMASK: begin
               wmerged = merge(32'(s_ff.imask), s_ff.wdata, s_ff.wstrb);
               nxt_s.imask = wmerged[flash_poll_pkg::IRQ_W-1:0];
            end
            flash_poll_pkg::OFF_STATUS: ;
            default: nxt_s.bresp = flash_poll_pkg::RESP_SLVERR;
         endcase
      end
      if (s_ff.bvalid && s_axi_bready) begin
         nxt_s.bvalid  = 1'b0;
         nxt_s.aw_got  = 1'b0;
         nxt_s.w_got   = 1'b0;
         nxt_s.awready = 1'b1;
         nxt_s.wready  = 1'b1;
      end
      // ======================================================
      // register bus, read side
      if (s_ff.arready && s_axi_arvalid) begin
         nxt_s.arready = 1'b0;
         nxt_s.rvalid  = 1'b1;
         nxt_s.rresp   = flash_poll_pkg::RESP_OKAY;
         case (s_axi_araddr)
            flash_poll_pkg::OFF_CTRL:   nxt_s.rdata = 32'(s_ff.auto_rst) <<
                                                      flash_poll_pkg::CTRL_AUTORST;
            flash_poll_pkg::OFF_ADDR:   nxt_s.rdata = 32'(s_ff.addr_reg);
            flash_poll_pkg::OFF_WDATA:  nxt_s.rdata = 32'(s_ff.wdata_reg);
            flash_poll_pkg::OFF_STATUS: nxt_s.rdata = status_word;
            flash_poll_pkg::OFF_ISTAT:  nxt_s.rdata = 32'(s_ff.istat);
            flash_poll_pkg::OFF_IMASK:  nxt_s.rdata = 32'(s_ff.imask);
            default: begin
               nxt_s.rdata = 32'h0;
               nxt_s.rresp = flash_poll_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_ff.rvalid && s_axi_rready) begin
         nxt_s.rvalid  = 1'b0;
         nxt_s.arready = 1'b1;
      end
      // ======================================================
      // flash cycle sequencer
      nxt_s.cnt = s_ff.cnt + 8'h1;
      case (s_ff.state)
         flash_poll_pkg::ST_IDLE: begin
            nxt_s.cnt = 8'h0;
            if (go) begin
               nxt_s.op      = flash_poll_pkg::op_t'(wmerged[flash_poll_pkg::CTRL_OP_LO +: 2]);
               nxt_s.nread   = 2'h0;
               nxt_s.fail_hi = 1'b0;
               nxt_s.abort   = 1'b0;
               nxt_s.sec_tog = 1'b0;
               nxt_s.result  = flash_poll_pkg::RES_NONE;
               nxt_s.fl_addr = s_ff.addr_reg;
               nxt_s.fl.ce_n = 1'b0;
               if (nxt_s.op == flash_poll_pkg::OP_POLL || nxt_s.op == flash_poll_pkg::OP_WINDOW) begin
                  nxt_s.fl.oe_n = 1'b0;
                  nxt_s.state   = flash_poll_pkg::ST_RD;
               end else begin
                  nxt_s.fl.dq_oe  = 1'b1;
                  nxt_s.fl.dq_out = (nxt_s.op == flash_poll_pkg::OP_RESET) ? RESET_CMD
                                                                           : s_ff.wdata_reg;
                  nxt_s.state     = flash_poll_pkg::ST_WR_SET;
               end
            end
         end
         flash_poll_pkg::ST_RD: begin
            // wait out access time plus the synchroniser, then take a settled byte
            if (s_ff.cnt >= cyc(flash_poll_pkg::ACC_CYC + flash_poll_pkg::SYNC_CYC) &&
                s_ff.dq_sync[1] == s_ff.dq_sync[2]) begin
               nxt_s.prev    = s_ff.cur;
               nxt_s.cur     = s_ff.dq_sync[2];
               nxt_s.nread   = (s_ff.nread == 2'h3) ? 2'h3 : s_ff.nread + 2'h1;
               nxt_s.fl.oe_n = 1'b1;
               nxt_s.fl.ce_n = 1'b1;
               nxt_s.state   = flash_poll_pkg::ST_EVAL;
            end
         end
         flash_poll_pkg::ST_EVAL: begin
            nxt_s.cnt   = 8'h0;
            nxt_s.state = flash_poll_pkg::ST_GAP;
            nxt_s.after = flash_poll_pkg::ST_IDLE;
            if (s_ff.op == flash_poll_pkg::OP_WINDOW) begin
               nxt_s.win    = s_ff.cur[flash_poll_pkg::BIT_WINDOW];
               nxt_s.result = flash_poll_pkg::RES_OK;
               ev_win       = 1'b1;
            end else if (s_ff.nread < 2'h2) begin
               nxt_s.after = flash_poll_pkg::ST_RD;
            end else begin
               if (s_ff.cur[flash_poll_pkg::BIT_SECTOR] ^ s_ff.prev[flash_poll_pkg::BIT_SECTOR]) begin
                  nxt_s.sec_tog = 1'b1;
               end
               if (!toggled) begin
                  nxt_s.result = flash_poll_pkg::RES_OK;
                  ev_ok        = 1'b1;
               end else if (s_ff.fail_hi) begin
                  nxt_s.result = flash_poll_pkg::RES_FAIL;
                  ev_fail      = 1'b1;
                  if (s_ff.auto_rst) begin
                     nxt_s.after = flash_poll_pkg::ST_WR_SET;
                     nxt_s.op    = flash_poll_pkg::OP_RESET;
                  end
               end else if (s_ff.cur[flash_poll_pkg::BIT_FAIL]) begin
                  nxt_s.fail_hi = 1'b1;
                  nxt_s.after   = flash_poll_pkg::ST_RD;
               end else if (s_ff.abort) begin
                  nxt_s.result = flash_poll_pkg::RES_ABORT;
               end else begin
                  nxt_s.after = flash_poll_pkg::ST_RD;
               end
            end
         end
         flash_poll_pkg::ST_GAP: begin
            if (s_ff.cnt >= cyc(flash_poll_pkg::GAP_CYC)) begin
               nxt_s.state = s_ff.after;
               nxt_s.cnt   = 8'h0;
               if (s_ff.after == flash_poll_pkg::ST_RD) begin
                  nxt_s.fl.ce_n = 1'b0;
                  nxt_s.fl.oe_n = 1'b0;
               end else if (s_ff.after == flash_poll_pkg::ST_WR_SET) begin
                  nxt_s.fl.ce_n   = 1'b0;
                  nxt_s.fl.dq_oe  = 1'b1;
                  nxt_s.fl.dq_out = RESET_CMD;
               end
            end
         end
         flash_poll_pkg::ST_WR_SET: begin
            nxt_s.fl.we_n = 1'b0;
            nxt_s.cnt     = 8'h0;
            nxt_s.state   = flash_poll_pkg::ST_WR;
         end
         flash_poll_pkg::ST_WR: begin
            if (s_ff.cnt >= cyc(flash_poll_pkg::WE_CYC - 1)) begin
               nxt_s.fl.we_n = 1'b1;
               nxt_s.state   = flash_poll_pkg::ST_WR_END;
            end
         end
         flash_poll_pkg::ST_WR_END: begin
            // data held one cycle past the rising write strobe
            nxt_s.fl.ce_n  = 1'b1;
            nxt_s.fl.dq_oe = 1'b0;
            ev_cmd         = 1'b1;
            nxt_s.cnt      = 8'h0;
            nxt_s.after    = flash_poll_pkg::ST_IDLE;
            nxt_s.state    = flash_poll_pkg::ST_GAP;
         end
         default: nxt_s.state = flash_poll_pkg::ST_IDLE;
      endcase
      // ======================================================
      // interrupts: hardware set beats software clear
      iset = '0;
      iset[flash_poll_pkg::IRQ_OK]   = ev_ok;
      iset[flash_poll_pkg::IRQ_FAIL] = ev_fail;
      iset[flash_poll_pkg::IRQ_WIN]  = ev_win && s_ff.cur[flash_poll_pkg::BIT_WINDOW];
      iset[flash_poll_pkg::IRQ_CMD]  = ev_cmd;
      nxt_s.istat = nxt_s.istat | iset;
      nxt_s.irq   = |(nxt_s.istat & nxt_s.imask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff         <= '0;
         s_ff.state   <= flash_poll_pkg::ST_IDLE;
         s_ff.after   <= flash_poll_pkg::ST_IDLE;
         s_ff.fl.ce_n <= 1'b1;
         s_ff.fl.oe_n <= 1'b1;
         s_ff.fl.we_n <= 1'b1;
         s_ff.awready <= 1'b1;
         s_ff.wready  <= 1'b1;
         s_ff.arready <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign s_axi_awready     = s_ff.awready;
   assign s_axi_wready      = s_ff.wready;
   assign s_axi_bvalid      = s_ff.bvalid;
   assign s_axi_bresp       = s_ff.bresp;
   assign s_axi_arready     = s_ff.arready;
   assign s_axi_rvalid      = s_ff.rvalid;
   assign s_axi_rdata       = s_ff.rdata;
   assign s_axi_rresp       = s_ff.rresp;
   assign flash_addr        = s_ff.fl_addr;
   assign flash_ce_n        = s_ff.fl.ce_n;
   assign flash_oe_n        = s_ff.fl.oe_n;
   assign flash_we_n        = s_ff.fl.we_n;
   assign low_data_byte_out = s_ff.fl.dq_out;
   assign low_data_byte_oe  = s_ff.fl.dq_oe;
   assign irq               = s_ff.irq;

   // ======================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   two_reads_a: assert property (ev_ok |-> s_ff.nread >= 2'h2 && !toggled)
      else $error("completion declared before two compared reads");
   fail_recheck_a: assert property (ev_fail |-> s_ff.fail_hi && s_ff.nread == 2'h3)
      else $error("failure declared without recheck after fail bit");
   fail_reset_a: assert property (ev_fail && s_ff.auto_rst |-> ##[1:20] !flash_we_n
      ##0 low_data_byte_out == RESET_CMD && low_data_byte_oe)
      else $error("reset command not issued after failure");
   restart_a: assert property (go && s_ff.state == flash_poll_pkg::ST_IDLE
      |=> s_ff.nread == 2'h0 && !s_ff.fail_hi)
      else $error("poll did not restart from the first read");
   read_addr_a: assert property (!flash_oe_n |-> flash_addr == s_ff.addr_reg
      && !low_data_byte_oe)
      else $error("status read without the selected address");
   window_take_a: assert property (ev_win |=>
      s_ff.win == $past(s_ff.cur[flash_poll_pkg::BIT_WINDOW]))
      else $error("window bit sample not recorded");
   irq_level_a: assert property (|(s_ff.istat & s_ff.imask) |-> irq)
      else $error("interrupt low with unmasked status set");
endmodule : flash_poll_ctrl
`default_nettype wire

// [flash_poll_pkg.sv]
`default_nettype none
package flash_poll_pkg;
   // ======================================================
   // clock and pin timing
   localparam int CLK_PS      = 8000;
   localparam int T_ACC_NS    = 100;
   localparam int T_WE_NS     = 50;
   localparam int T_GAP_NS    = 30;
   localparam int ACC_CYC     = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int WE_CYC      = (T_WE_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int GAP_CYC     = (T_GAP_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int SYNC_CYC    = 3;
   // ======================================================
   // register offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_ADDR   = 8'h04;
   localparam logic [7:0] OFF_WDATA  = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_ISTAT  = 8'h10;
   localparam logic [7:0] OFF_IMASK  = 8'h14;
   // ======================================================
   // field positions
   localparam int CTRL_GO     = 0;
   localparam int CTRL_OP_LO  = 1;
   localparam int CTRL_ABORT  = 3;
   localparam int CTRL_AUTORST = 4;
   localparam int BIT_POLARITY = 7;
   localparam int BIT_TOGGLE  = 6;
   localparam int BIT_FAIL    = 5;
   localparam int BIT_WINDOW  = 3;
   localparam int BIT_SECTOR  = 2;
   localparam int IRQ_W       = 4;
   localparam int IRQ_OK      = 0;
   localparam int IRQ_FAIL    = 1;
   localparam int IRQ_WIN     = 2;
   localparam int IRQ_CMD     = 3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ======================================================
   // operations, results, states
   typedef enum logic [1:0] {
      OP_POLL = 2'h0, OP_WINDOW = 2'h1, OP_WRITE = 2'h2, OP_RESET = 2'h3
   } op_t;
   typedef enum logic [1:0] {
      RES_NONE = 2'h0, RES_OK = 2'h1, RES_FAIL = 2'h2, RES_ABORT = 2'h3
   } res_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_RD = 3'h1, ST_EVAL = 3'h3, ST_GAP = 3'h2,
      ST_WR_SET = 3'h6, ST_WR = 3'h7, ST_WR_END = 3'h5
   } state_t;
   typedef struct packed {
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        dq_oe;
      logic [7:0]  dq_out;
   } flash_ctl_t;
endpackage : flash_poll_pkg
`default_nettype wire

// [flash_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
   parameter logic [7:0] RESET_CMD = 8'hf0,
   parameter int         OP_READS  = 8,
   parameter int         FAIL_RDS  = 3,
   parameter int         WIN_NS    = 1000,
   parameter logic [4:0] SECT      = 5'h01
) (
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [20:0] addr,
   input  wire logic [7:0]  dq_in,
   input  wire logic        erase_go,
   input  wire logic        chip,
   output logic [7:0]       dq_out,
   output logic             ready_busy
);
   // ==========
   // array and sequencer state
   logic [7:0] mem [logic [20:0]];
   logic [7:0] cur;
   logic [7:0] pdat;
   logic       busy, fail, erasing, tog, stog;
   int         n;
   realtime    t_win;
   initial begin
      {busy, fail, erasing, tog, stog, cur, pdat} = '0;
      n = 0;
      t_win = 0;
   end
   function automatic logic [7:0] arr(input logic [20:0] a);
      return mem.exists(a) ? mem[a] : 8'hff;
   endfunction : arr
   function automatic logic win();
      return erasing && !chip && ($realtime - t_win >= WIN_NS);
   endfunction : win
   // released bus shows the inverse of the last byte, so a stale value never passes
   assign dq_out     = (!ce_n && !oe_n) ? cur : ~cur;
   assign ready_busy = !busy;
   always @(negedge oe_n) begin
      // both strobes fall on one edge; let chip enable settle before looking at it
      #1;
      if (!ce_n && busy) begin
         n++;
         tog = ~tog;
         if (erasing && addr[20:16] == SECT) stog = ~stog;
         if (!fail && n > OP_READS) begin
            busy = 1'b0;
            if (erasing) mem.delete();
            erasing = 1'b0;
         end
      end
      if (!ce_n && !busy) cur = arr(addr);
      else if (!ce_n) cur = {erasing ? 1'b0 : ~pdat[7], tog, fail && n > FAIL_RDS, 1'b0,
                             win(), stog, 2'h0};
   end
   always @(posedge we_n) begin
      if (!ce_n) begin
         if (dq_in == RESET_CMD) begin
            if (fail) {busy, fail} = 2'h0;
         end else if (erasing) begin
            if (dq_in == 8'h30 && !win()) t_win = $realtime;
         end else if (!busy) begin
            pdat = dq_in;
            n = 0;
            busy = 1'b1;
            fail = |(dq_in & ~arr(addr));
            if (!fail) mem[addr] = dq_in;
         end
      end
   end
   always @(posedge erase_go) begin
      {erasing, busy, fail} = 3'h6;
      n = 0;
      t_win = $realtime;
   end
endmodule : flash_dev_model
`default_nettype wire

// [flash_write_status_polling_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_write_status_polling_tb_top;
   typedef struct packed {logic [31:0] e; logic [31:0] m; logic [1:0] r;} note_t;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic        ce_n, oe_n, we_n, dq_oe, rdy, erase_go, chip;
   logic [7:0]  awaddr, araddr, dq_o, dev_q, dat;
   logic [31:0] wdata, rdata, last_rd;
   logic [1:0]  bresp, rresp;
   logic [20:0] f_addr, adr;
   note_t       rq[$];
   logic [1:0]  bq[$];
   int          failures, n_checks;
   flash_poll_ctrl u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .flash_addr(f_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .low_data_byte_out(dq_o), .low_data_byte_oe(dq_oe),
      .low_data_byte_in(dq_oe ? dq_o : dev_q), .ready_busy_pin(rdy), .irq(irq));
   flash_dev_model u_dev (
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr), .dq_in(dq_o),
      .erase_go(erase_go), .chip(chip), .dq_out(dev_q), .ready_busy(rdy));
   // ==========
   // compare and report
   task automatic chk_bit(input logic [1:0] got, input logic [1:0] want);
      n_checks++;
      if (got !== want) begin
         failures++;
         $display("Error at %0t: got %h want %h", $time, got, want);
      end
   endtask : chk_bit
   task automatic chk_word(input note_t nt, input logic [31:0] d, input logic [1:0] r);
      n_checks++;
      if ((d & nt.m) !== nt.e || r !== nt.r) begin
         failures++;
         $display("Error at %0t: read %h resp %h want %h resp %h", $time, d, r, nt.e, nt.r);
      end
   endtask : chk_word
   task automatic end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   always @(posedge aclk) begin
      if (bvalid && bready) chk_bit(bresp, bq.pop_front());
      if (rvalid && rready) chk_word(rq.pop_front(), rdata, rresp);
   end
   // ==========
   // bus master tasks
   // no answer time is assumed: only the watchdog ends a wait
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      bq.push_back(r);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
      @(posedge aclk);
      rq.push_back('{e, m, r});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      last_rd = rdata;
      rready <= 1'b0;
   endtask : rd
   task automatic wait_idle();
      do begin
         rd(flash_poll_pkg::OFF_STATUS, 0, 0, flash_poll_pkg::RESP_OKAY);
      end while (last_rd[0] !== 1'b0);
   endtask : wait_idle
   task automatic run(input logic [1:0] op, input logic ar, input logic w);
      wr(flash_poll_pkg::OFF_CTRL, {27'h0, ar, 1'b0, op, 1'b1}, flash_poll_pkg::RESP_OKAY);
      if (w) wait_idle();
   endtask : run
   task automatic st(input logic [31:0] e, m);
      rd(flash_poll_pkg::OFF_STATUS, e, m, flash_poll_pkg::RESP_OKAY);
   endtask : st
   task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
      wr(a, d, flash_poll_pkg::RESP_OKAY);
   endtask : reg_w
   task automatic erase(input logic c);
      @(posedge aclk);
      chip <= c; erase_go <= 1'b1;
      @(posedge aclk);
      erase_go <= 1'b0;
   endtask : erase
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   initial begin
      repeat (40000) @(posedge aclk);
      failures++;
      end_sim();
   end
   // ==========
   // scenarios
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, erase_go, chip} = '0;
      {awaddr, araddr, wdata} = '0;
      failures = 0;
      n_checks = 0;
      void'($urandom(64));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      st(0, 32'h7);
      rd(flash_poll_pkg::OFF_IMASK, 0, 32'hf, flash_poll_pkg::RESP_OKAY);
      rd(8'h20, 0, 32'hffffffff, flash_poll_pkg::RESP_SLVERR);
      wr(8'h24, 32'h1, flash_poll_pkg::RESP_SLVERR);
      run(flash_poll_pkg::OP_POLL, 1'b0, 1'b1);
      st(32'h22, 32'h27);
      chk_bit(irq, 0);
      reg_w(flash_poll_pkg::OFF_IMASK, 32'h3);
      repeat (2) @(posedge aclk);
      chk_bit(irq, 1);
      reg_w(flash_poll_pkg::OFF_ISTAT, 32'hf);
      repeat (2) @(posedge aclk);
      chk_bit(irq, 0);
      adr = 21'($urandom);
      // bit7 clear keeps the byte off the reset command, bit0 clear lets a later 1 fail
      dat = 8'($urandom) & 8'h7e;
      reg_w(flash_poll_pkg::OFF_ADDR, 32'(adr));
      rd(flash_poll_pkg::OFF_ADDR, 32'(adr), 32'hffffffff, flash_poll_pkg::RESP_OKAY);
      reg_w(flash_poll_pkg::OFF_WDATA, 32'(dat));
      run(flash_poll_pkg::OP_WRITE, 1'b0, 1'b1);
      rd(flash_poll_pkg::OFF_ISTAT, 32'h8, 32'h8, flash_poll_pkg::RESP_OKAY);
      run(flash_poll_pkg::OP_POLL, 1'b0, 1'b1);
      st({dat, 8'h22}, 32'hff27);
      chk_bit(irq, 1);
      reg_w(flash_poll_pkg::OFF_ISTAT, 32'hf);
      run(flash_poll_pkg::OP_RESET, 1'b0, 1'b1);
      rd(flash_poll_pkg::OFF_ISTAT, 32'h8, 32'h8, flash_poll_pkg::RESP_OKAY);
      reg_w(flash_poll_pkg::OFF_WDATA, 32'hff);
      run(flash_poll_pkg::OP_WRITE, 1'b0, 1'b1);
      run(flash_poll_pkg::OP_POLL, 1'b1, 1'b1);
      st(32'h4, 32'h7);
      rd(flash_poll_pkg::OFF_ISTAT, 32'h2, 32'h2, flash_poll_pkg::RESP_OKAY);
      chk_bit(irq, 1);
      run(flash_poll_pkg::OP_POLL, 1'b0, 1'b1);
      st({dat, 8'h02}, 32'hff07);
      reg_w(flash_poll_pkg::OFF_ADDR, 32'h0001_2345);
      reg_w(flash_poll_pkg::OFF_WDATA, 32'h30);
      erase(1'b0);
      repeat (80) @(posedge aclk);
      run(flash_poll_pkg::OP_WRITE, 1'b0, 1'b1);
      repeat (30) @(posedge aclk);
      run(flash_poll_pkg::OP_WINDOW, 1'b0, 1'b1);
      st(0, 32'h8);
      repeat (150) @(posedge aclk);
      run(flash_poll_pkg::OP_WINDOW, 1'b0, 1'b1);
      st(32'h8, 32'h8);
      rd(flash_poll_pkg::OFF_ISTAT, 32'h4, 32'h4, flash_poll_pkg::RESP_OKAY);
      run(flash_poll_pkg::OP_WRITE, 1'b0, 1'b1);
      run(flash_poll_pkg::OP_WINDOW, 1'b0, 1'b1);
      st(32'h8, 32'h8);
      run(flash_poll_pkg::OP_POLL, 1'b0, 1'b1);
      st(32'h12, 32'h17);
      erase(1'b1);
      repeat (150) @(posedge aclk);
      run(flash_poll_pkg::OP_WINDOW, 1'b0, 1'b1);
      st(0, 32'h8);
      // abort lands while the chip erase still toggles
      run(flash_poll_pkg::OP_POLL, 1'b0, 1'b0);
      reg_w(flash_poll_pkg::OFF_CTRL, 32'h8);
      wait_idle();
      st(32'h6, 32'h7);
      run(flash_poll_pkg::OP_POLL, 1'b0, 1'b1);
      st(32'h2, 32'h7);
      end_sim();
   end
endmodule : flash_write_status_polling_tb_top
`default_nettype wire
